// ### src/csl_top.sv
/*
  Card save/load sequencer: buttons, lamps, serial link to the motion
  controller, byte port to the card, Avalon-MM register slave.
  Assumes all inputs synchronous to core_clk and a card port that
  answers writes and reads with the handshake described at its ports.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Power-up: both lamps flash five times
// - Buttons ignored during power-up flashing
// - Save button copies controller to card
// - Save erases existing card data first
// - Save allowed while controller program runs
// - Load button copies card to controller
// - Empty card: load sends nothing
// - No load while controller program runs
// - Errors checked after a button press
// - Link fault: both lamps, one second
// - Write fault: save lamp, one second
// - Detect missing card on any request
// - Missing card: requested lamp, half second
// - Any button clears error to idle
// - All data goes over the serial port
// - Whole data set moves as one batch
// - Load takes ten percent longer
module csl_top #(
  parameter int unsigned TICK_CYC = csl_pkg::BLINK_CYC,
  parameter int unsigned TMO = csl_pkg::TMO_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Front panel
  input wire logic btn_save,
  input wire logic btn_load,
  output logic lamp_save,
  output logic lamp_load,
  // Controller serial port and run state
  output logic txd,
  input wire logic rxd,
  input wire logic prog_running,
  // Card byte port
  input wire logic card_present,
  input wire logic card_has_data,
  input wire logic card_busy,
  input wire logic card_fail,
  output logic card_erase,
  output logic card_wr,
  output logic [7:0] card_wdata,
  output logic card_rd,
  input wire logic card_rvalid,
  input wire logic [7:0] card_rdata,
  input wire logic card_rlast,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  import csl_pkg::*;

  csl_state_e state; // Sequencer state
  csl_err_e err; // Error shown on lamps
  logic err_load; // Missing card was seen on a load
  logic [3:0] pw_cnt; // Power-up toggle count
  logic [1:0] ph; // Blink phase
  logic tick; // Quarter-second enable
  logic btn_save_q, btn_load_q; // Button history
  logic [2:0] sw_go; // Software start/clear pulses
  logic p_save, p_load, p_any; // Press events
  logic [31:0] tmr; // Link silence timer
  logic got; // Save received at least one byte
  logic last_q; // Byte in flight is the final one
  logic [15:0] xcnt; // Bytes moved in this transfer
  logic [3:0] ev; // Event pulses to interrupt status
  logic [3:0] irq_stat, irq_mask; // Interrupt registers
  logic ack; // Bus answer phase
  logic wr_en; // Register write strobe
  logic tx_start, tx_busy, tx_xstop; // Transmit handshake
  logic [7:0] tx_data; // Byte to controller
  logic rx_valid, rx_ferr; // Receive events
  logic [7:0] rx_data; // Byte from controller

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction

  csl_tick #(.DIV(TICK_CYC)) u_tick (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(tick)
  );

  csl_uart u_uart (
    .core_clk(core_clk),
    .nrst(nrst),
    .tx_start(tx_start),
    .tx_data(tx_data),
    .tx_xstop(tx_xstop),
    .tx_busy(tx_busy),
    .txd(txd),
    .rxd(rxd),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ferr(rx_ferr)
  );

  // Buttons and software writes both act as presses
  assign p_save = (btn_save & ~btn_save_q) | sw_go[CTRL_SAVE];
  assign p_load = (btn_load & ~btn_load_q) | sw_go[CTRL_LOAD];
  assign p_any = p_save | p_load | sw_go[CTRL_CLR];

  // Button edge history
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      btn_save_q <= 1'b0;
      btn_load_q <= 1'b0;
    end
    else
    begin
      btn_save_q <= btn_save;
      btn_load_q <= btn_load;
    end
  end

  // Blink phase; bit 0 half-second period, bit 1 one second
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ph <= 2'h0;
    else if (tick)
      ph <= ph + 2'h1;
  end

  // Main sequence
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_PWRUP;
      err <= E_NONE;
      err_load <= 1'b0;
      pw_cnt <= 4'h0;
      tmr <= 32'h0;
      got <= 1'b0;
      last_q <= 1'b0;
      xcnt <= 16'h0;
      ev <= 4'h0;
      tx_start <= 1'b0;
      tx_data <= 8'h00;
      tx_xstop <= 1'b0;
      card_erase <= 1'b0;
      card_wr <= 1'b0;
      card_wdata <= 8'h00;
      card_rd <= 1'b0;
    end
    else
    begin
      // Strobes last one cycle
      ev <= 4'h0;
      tx_start <= 1'b0;
      card_erase <= 1'b0;
      card_wr <= 1'b0;
      card_rd <= 1'b0;
      case (state)
        S_PWRUP:
        begin
          // presses are not looked at here
          if (tick)
          begin
            pw_cnt <= pw_cnt + 4'h1;
            if (pw_cnt == PWR_TOGGLES - 4'h1)
              state <= S_IDLE;
          end
        end
        S_IDLE:
        begin
          got <= 1'b0;
          tmr <= 32'h0;
          if (p_save && !card_present)
          begin
            state <= S_ERR;
            err <= E_NOCARD;
            err_load <= 1'b0;
            ev[IRQ_ERR] <= 1'b1;
          end
          else if (p_save)
          begin
            state <= S_SCMD;
            tx_start <= 1'b1;
            tx_data <= CMD_SAVE;
            tx_xstop <= 1'b0;
            // Count restarts here so it stays readable after the save
            xcnt <= 16'h0;
          end
          else if (p_load && !card_present)
          begin
            state <= S_ERR;
            err <= E_NOCARD;
            err_load <= 1'b1;
            ev[IRQ_ERR] <= 1'b1;
          end
          else if (p_load && (prog_running || !card_has_data))
            ev[IRQ_REF] <= 1'b1;
          else if (p_load)
          begin
            state <= S_LCMD;
            tx_start <= 1'b1;
            tx_data <= CMD_LOAD;
            tx_xstop <= 1'b1;
            xcnt <= 16'h0;
          end
        end
        // Request byte leaving for the controller
        S_SCMD:
        begin
          if (!tx_start && !tx_busy)
          begin
            if (card_has_data)
            begin
              state <= S_ERASE;
              card_erase <= 1'b1;
            end
            else
              state <= S_SRX;
          end
        end
        // Waiting for erase to finish
        S_ERASE:
        begin
          if (card_fail)
          begin
            state <= S_ERR;
            err <= E_WRITE;
            ev[IRQ_ERR] <= 1'b1;
          end
          else if (!card_erase && !card_busy)
            state <= S_SRX;
        end
        // the whole batch streams in until silence
        S_SRX:
        begin
          if (rx_ferr || (tmr == 32'(TMO - 1) && !got))
          begin
            state <= S_ERR;
            err <= E_COMM;
            ev[IRQ_ERR] <= 1'b1;
          end
          else if (card_fail)
          begin
            state <= S_ERR;
            err <= E_WRITE;
            ev[IRQ_ERR] <= 1'b1;
          end
          else if (rx_valid)
          begin
            card_wr <= 1'b1;
            card_wdata <= rx_data;
            xcnt <= xcnt + 16'h1;
            got <= 1'b1;
            tmr <= 32'h0;
          end
          else if (tmr == 32'(TMO - 1))
          begin
            state <= S_IDLE;
            ev[IRQ_SDONE] <= 1'b1;
          end
          else
            tmr <= tmr + 32'h1;
        end
        // Request byte out, fetch first card byte
        S_LCMD:
        begin
          if (!tx_start && !tx_busy)
          begin
            state <= S_LRD;
            card_rd <= 1'b1;
          end
        end
        // Card byte arrives and is sent on
        S_LRD:
        begin
          if (card_rvalid)
          begin
            state <= S_LTX;
            tx_start <= 1'b1;
            tx_data <= card_rdata;
            last_q <= card_rlast;
            xcnt <= xcnt + 16'h1;
          end
        end
        // eleven-bit frames make load a tenth slower
        S_LTX:
        begin
          if (!tx_start && !tx_busy)
          begin
            if (last_q)
            begin
              state <= S_IDLE;
              ev[IRQ_LDONE] <= 1'b1;
            end
            else
            begin
              state <= S_LRD;
              card_rd <= 1'b1;
            end
          end
        end
        S_ERR:
        begin
          if (p_any)
          begin
            state <= S_IDLE;
            err <= E_NONE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Lamp drive
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lamp_save <= 1'b0;
      lamp_load <= 1'b0;
    end
    else
    begin
      lamp_save <= 1'b0;
      lamp_load <= 1'b0;
      if (state == S_PWRUP)
      begin
        lamp_save <= !pw_cnt[0];
        lamp_load <= !pw_cnt[0];
      end
      else if (state == S_SCMD || state == S_ERASE || state == S_SRX)
        lamp_save <= ph[0];
      else if (state == S_LCMD || state == S_LRD || state == S_LTX)
        lamp_load <= ph[0];
      else if (state == S_ERR)
      begin
        lamp_save <= (err == E_COMM || err == E_WRITE) ? ph[1] :
                     (err == E_NOCARD && !err_load) ? ph[0] : 1'b0;
        lamp_load <= (err == E_COMM) ? ph[1] :
                     (err == E_NOCARD && err_load) ? ph[0] : 1'b0;
      end
    end
  end

  // Bus: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en = avs_write & ack & avs_byteenable[0];

  // Answer phase tracker
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  // Read data, captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h0;
    else if (avs_read && !ack)
    begin
      avs_readdata <= 32'h0;
      if (hit(avs_address, ADR_STATUS))
        avs_readdata <= {19'h0, prog_running, card_present, err, state};
      else if (hit(avs_address, ADR_IRQ_STAT))
        avs_readdata <= {28'h0, irq_stat};
      else if (hit(avs_address, ADR_IRQ_MASK))
        avs_readdata <= {28'h0, irq_mask};
      else if (hit(avs_address, ADR_COUNT))
        avs_readdata <= {16'h0, xcnt};
    end
  end

  // Control pulses, mask, sticky status; a new event beats its clear
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sw_go <= 3'h0;
      irq_mask <= 4'h0;
      irq_stat <= 4'h0;
    end
    else
    begin
      sw_go <= (wr_en && hit(avs_address, ADR_CTRL)) ?
               avs_writedata[2:0] : 3'h0;
      if (wr_en && hit(avs_address, ADR_IRQ_MASK))
        irq_mask <= avs_writedata[3:0];
      if (wr_en && hit(avs_address, ADR_IRQ_STAT))
        irq_stat <= (irq_stat & ~avs_writedata[3:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_pwrup_no_go: assert property (
    state == S_PWRUP |=> state inside {S_PWRUP, S_IDLE})
    else $error("transfer left power-up");
  a_pwrup_len: assert property (
    state == S_PWRUP && tick && pw_cnt == 4'h9 |=> state == S_IDLE)
    else $error("power-up flash count wrong");
  a_nocard_err: assert property (
    state == S_IDLE && (p_save || p_load) && !card_present
    |=> state == S_ERR && err == E_NOCARD)
    else $error("missing card not flagged");
  a_load_block: assert property (
    state == S_IDLE && !p_save && p_load && card_present && prog_running
    |=> state == S_IDLE && ev[IRQ_REF])
    else $error("load ran during program");
  a_empty_load: assert property (
    state == S_IDLE && !p_save && p_load && card_present
    && !card_has_data |=> state == S_IDLE ##1 !card_rd)
    else $error("empty card was loaded");
  a_erase_first: assert property (
    state == S_SCMD ##1 state == S_ERASE |-> $past(card_has_data)
    && card_erase)
    else $error("erase skipped");
  a_err_hold: assert property (
    state == S_ERR && !p_any |=> state == S_ERR && !card_wr)
    else $error("error dropped without press");
  a_err_clear: assert property (
    state == S_ERR && p_any |=> state == S_IDLE)
    else $error("press did not clear error");
  a_comm_lamps: assert property (
    state == S_ERR && err == E_COMM ##1 state == S_ERR
    |-> lamp_save == lamp_load)
    else $error("link fault lamps differ");
  a_save_lamp: assert property (
    state == S_SRX ##1 state == S_SRX |-> !lamp_load)
    else $error("load lamp lit during save");

  c_save_done: cover property (ev[IRQ_SDONE]);
  c_load_done: cover property (ev[IRQ_LDONE]);
  c_nocard: cover property (state == S_ERR && err == E_NOCARD);
  c_comm_err: cover property (state == S_ERR && err == E_COMM);
endmodule

// ### src/csl_pkg.sv
/*
  Shared constants and types of the card save/load sequencer.
  Assumes a 100 MHz core clock; no other file redefines these values.
*/
package csl_pkg;
  // Core clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  // Blink prescaler step: a quarter of the one second error period
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  // Silence on the serial link that ends a save, or flags a fault
  localparam int unsigned TMO_MS = 100;
  localparam int unsigned TMO_CYC = CLK_HZ / 1000 * TMO_MS;
  // Serial link rate and bit time in cycles
  localparam int unsigned BAUD_RATE = 38400;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_RATE);
  localparam logic [15:0] BAUD_HALF = 16'(CLK_HZ / BAUD_RATE / 2);
  // Lamp toggles at power-up: five flashes
  localparam logic [3:0] PWR_TOGGLES = 4'hA;
  // Request bytes sent to the controller
  localparam logic [7:0] CMD_SAVE = 8'h53;
  localparam logic [7:0] CMD_LOAD = 8'h4C;
  // Register byte offsets
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_STATUS = 5'h04;
  localparam logic [4:0] ADR_IRQ_STAT = 5'h08;
  localparam logic [4:0] ADR_IRQ_MASK = 5'h0C;
  localparam logic [4:0] ADR_COUNT = 5'h10;
  // Control bits
  localparam int CTRL_SAVE = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_CLR = 2;
  // Interrupt status bits
  localparam int IRQ_SDONE = 0;
  localparam int IRQ_LDONE = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_REF = 3;
  // Sequencer states
  typedef enum logic [8:0] {
    S_PWRUP = 9'h001, S_IDLE = 9'h002, S_SCMD = 9'h004,
    S_ERASE = 9'h008, S_SRX = 9'h010, S_LCMD = 9'h020,
    S_LRD = 9'h040, S_LTX = 9'h080, S_ERR = 9'h100
  } csl_state_e;
  // Error kinds
  typedef enum logic [1:0] {
    E_NONE = 2'h0, E_COMM = 2'h1, E_WRITE = 2'h2, E_NOCARD = 2'h3
  } csl_err_e;
endpackage

// ### src/csl_tick.sv
/*
  Blink prescaler: one-cycle enable pulse every DIV core clocks.
  Assumes a single free-running core clock.
*/
`timescale 1ns/100ps
module csl_tick #(
  parameter int unsigned DIV = csl_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Enable pulse
  output logic tick
);
  import csl_pkg::*;

  // Prescaler count
  logic [31:0] cnt;

  // Free-running divider
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt == 32'(DIV - 1))
    begin
      cnt <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ### src/csl_uart.sv
/*
  Byte serial port, 8N1, LSB first, one optional extra stop bit.
  Assumes rxd is already synchronous to core_clk.
*/
`timescale 1ns/100ps
module csl_uart (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Transmit side
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  input wire logic tx_xstop,
  output logic tx_busy,
  output logic txd,
  // Receive side
  input wire logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_ferr
);
  import csl_pkg::*;

  logic [10:0] tsh; // Frame shifter, idles all ones
  logic [3:0] tbits; // Bits left in frame
  logic [15:0] tcnt; // Bit timer
  logic rbusy; // Receiving a frame
  logic [3:0] rbits; // Bit index in frame
  logic [15:0] rcnt; // Bit timer

  assign txd = tsh[0];

  // Transmitter; the extra stop bit stretches a frame by a tenth
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tsh <= 11'h7FF;
      tbits <= 4'h0;
      tcnt <= 16'h0;
      tx_busy <= 1'b0;
    end
    else if (!tx_busy)
    begin
      if (tx_start)
      begin
        tsh <= {2'b11, tx_data, 1'b0};
        tbits <= tx_xstop ? 4'hB : 4'hA;
        tcnt <= 16'h0;
        tx_busy <= 1'b1;
      end
    end
    else if (tcnt == BAUD_DIV - 16'h1)
    begin
      tcnt <= 16'h0;
      tsh <= {1'b1, tsh[10:1]};
      tbits <= tbits - 4'h1;
      tx_busy <= (tbits != 4'h1);
    end
    else
      tcnt <= tcnt + 16'h1;
  end

  // Receiver; sampling starts mid-bit after the start edge
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rbusy <= 1'b0;
      rbits <= 4'h0;
      rcnt <= 16'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_ferr <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      rx_ferr <= 1'b0;
      if (!rbusy)
      begin
        if (!rxd)
        begin
          rbusy <= 1'b1;
          rbits <= 4'h0;
          rcnt <= BAUD_HALF;
        end
      end
      else if (rcnt == BAUD_DIV - 16'h1)
      begin
        rcnt <= 16'h0;
        rbits <= rbits + 4'h1;
        // Glitch on start bit: drop it quietly
        if (rbits == 4'h0)
          rbusy <= !rxd;
        else if (rbits == 4'h9)
        begin
          rbusy <= 1'b0;
          rx_valid <= rxd;
          rx_ferr <= !rxd;
        end
        else
          rx_data <= {rxd, rx_data[7:1]};
      end
      else
        rcnt <= rcnt + 16'h1;
    end
  end
endmodule

// ### tb/csl_ctl_model.sv
/*
  Behavioural motion controller on the far side of the serial link.
  Assumes 8N1 framing at the package baud rate, idle high, and one
  shared core clock; bytes are paced by counting core clock edges.
*/
`timescale 1ns/100ps
module csl_ctl_model (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  import csl_pkg::*;
  // Bit time in core clocks
  localparam int BIT = int'(BAUD_DIV);
  // Bytes heard from the unit
  logic [7:0] got_q[$];
  // Bytes to answer a save request with
  logic [7:0] send_q[$];
  // Time of the last start bit seen
  time t_start;

  // Line idles high between frames
  initial rxd = 1'b1;

  // Wait a number of clock edges
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Send one frame, LSB first, changing only after an edge
  task automatic put(input logic [7:0] b);
    int i;
    rxd <= 1'b0;
    wt(BIT);
    for (i = 0; i < 8; i++)
    begin
      rxd <= b[i];
      wt(BIT);
    end
    rxd <= 1'b1;
    wt(BIT);
  endtask

  // serial only path
  // Receiver; a save request is answered after a short think time
  always
  begin : rx_proc
    logic [7:0] b;
    int i;
    wait (txd === 1'b0);
    t_start = $time;
    wt(BIT / 2);
    for (i = 0; i < 8; i++)
    begin
      wt(BIT);
      b[i] = txd;
    end
    wt(BIT);
    // A bad stop bit drops the byte, so the bench sees it missing
    if (txd === 1'b1)
      got_q.push_back(b);
    if (b == CMD_SAVE)
    begin
      wt(2 * BIT);
      while (send_q.size() > 0)
        put(send_q.pop_front());
    end
  end
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench of the card save/load sequencer.
  Assumes csl_top with a shortened blink step and silence timeout.
*/
`timescale 1ns/100ps
module testbench;
  import csl_pkg::*;
  // Shortened counts; silence must outlast the reply gap of a save
  // (request frame end to first reply byte, about 28,700 cycles)
  localparam int unsigned TK = 8;
  localparam int unsigned TM = 32000;
  localparam int BIT = int'(BAUD_DIV);
  // Stimulus
  logic core_clk = 1'b0, nrst = 1'b0;
  logic btn_save = 1'b0, btn_load = 1'b0, prog_running = 1'b0;
  logic card_present = 1'b1, card_has_data = 1'b1;
  logic card_busy = 1'b0, card_fail = 1'b0, card_rvalid = 1'b0;
  logic card_rlast = 1'b0;
  logic [7:0] card_rdata = 8'h00;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  // Observed
  logic lamp_save, lamp_load, txd, rxd, card_erase, card_wr, card_rd;
  logic avs_waitrequest, irq;
  logic [7:0] card_wdata;
  logic [31:0] avs_readdata, q;
  // Bench state and reference queues
  int errors = 0, n_tests = 0, seed = 24551;
  int tog_s, tog_l, rise_s, erased, bcnt, rd_pend, k;
  logic ls_d = 1'b0, ll_d = 1'b0;
  logic [7:0] card_q[$];
  logic [7:0] exp_q[$];

  always #5 core_clk = ~core_clk;

  csl_top #(.TICK_CYC(TK), .TMO(TM)) dut (.core_clk, .nrst, .btn_save,
    .btn_load, .lamp_save, .lamp_load, .txd, .rxd, .prog_running,
    .card_present, .card_has_data, .card_busy, .card_fail, .card_erase,
    .card_wr, .card_wdata, .card_rd, .card_rvalid, .card_rdata,
    .card_rlast, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  csl_ctl_model ctl (.core_clk, .txd, .rxd);

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One Avalon cycle; held until a rising edge sees waitrequest low,
  // only the watchdog ends a wait that never gets its answer
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Press and release a button
  task automatic press(input int sv);
    @(posedge core_clk);
    if (sv != 0)
      btn_save <= 1'b1;
    else
      btn_load <= 1'b1;
    repeat (3) @(posedge core_clk);
    btn_save <= 1'b0;
    btn_load <= 1'b0;
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq;
    int i;
    for (i = 0; i < 200000 && irq !== 1'b1; i++)
      @(negedge core_clk);
  endtask

  // Lamp monitor and card write checks, on settled values
  always @(negedge core_clk)
  begin
    tog_s += (lamp_save !== ls_d);
    tog_l += (lamp_load !== ll_d);
    rise_s += (lamp_save === 1'b1 && ls_d === 1'b0);
    ls_d = lamp_save;
    ll_d = lamp_load;
    if (card_erase === 1'b1)
    begin
      erased = 1;
      bcnt = 6;
    end
    if (card_rd === 1'b1)
      rd_pend = 1;
    if (card_wr === 1'b1)
    begin
      chk(erased, 1);
      chk(card_wdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
  end

  // Card model: erase keeps busy a while, reads answer one byte
  always @(posedge core_clk)
  begin
    card_rvalid <= 1'b0;
    card_busy <= (bcnt != 0);
    if (bcnt != 0)
      bcnt--;
    if (rd_pend == 1 && card_q.size() > 0)
    begin
      card_rvalid <= 1'b1;
      card_rdata <= card_q.pop_front();
      card_rlast <= (card_q.size() == 0);
      rd_pend = 0;
    end
  end

  // Watchdog: well beyond the expected run of about 145k cycles
  initial
  begin
    #2_000_000;
    errors++;
    results();
  end

  initial
  begin
    erased = 0;
    bcnt = 0;
    rd_pend = 0;
    rise_s = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    // Power-up: press is ignored, lamps flash together
    press(1);
    repeat (9 * TK - 8) @(posedge core_clk);
    bus(0, ADR_STATUS, 0);
    chk(q[8:0], 9'h001);
    repeat (3 * TK) @(posedge core_clk);
    bus(0, ADR_STATUS, 0);
    chk(q[8:0], 9'h002);
    chk(rise_s, 5);
    chk(tog_s, tog_l);
    // Missing card on save: error held, half second blink
    card_present <= 1'b0;
    press(1);
    repeat (4) @(posedge core_clk);
    bus(0, ADR_STATUS, 0);
    chk(q[10:0], {E_NOCARD, 9'h100});
    tog_s = 0;
    tog_l = 0;
    repeat (16 * TK) @(posedge core_clk);
    chk(tog_s, 16);
    chk(tog_l, 0);
    bus(0, ADR_IRQ_STAT, 0);
    chk(q[IRQ_ERR], 1'b1);
    card_present <= 1'b1;
    press(0);
    repeat (300) @(posedge core_clk);
    bus(0, ADR_STATUS, 0);
    chk(q[8:0], 9'h002);
    chk(ctl.got_q.size(), 0);
    bus(1, ADR_IRQ_STAT, 32'hF);
    // Refused loads: running program, then empty card
    for (k = 0; k < 2; k++)
    begin
      prog_running <= (k == 0);
      card_has_data <= (k == 0);
      press(0);
      repeat (300) @(posedge core_clk);
      bus(0, ADR_IRQ_STAT, 0);
      chk(q[3:0], 4'h8);
      chk(ctl.got_q.size(), 0);
      @(negedge core_clk);
      chk(irq, 1'b0);
      bus(1, ADR_IRQ_MASK, 32'h8);
      @(negedge core_clk);
      chk(irq, 1'b1);
      bus(1, ADR_IRQ_STAT, 32'h8);
      @(negedge core_clk);
      chk(irq, 1'b0);
      bus(1, ADR_IRQ_MASK, 32'h0);
    end
    // Unmapped place and write-only control read as zero
    bus(0, 5'h14, 0);
    chk(q, 32'h0);
    bus(0, ADR_CTRL, 0);
    chk(q, 32'h0);
    // Save over a full card while the program runs
    prog_running <= 1'b1;
    card_has_data <= 1'b1;
    k = xs();
    exp_q.push_back(k[7:0]);
    ctl.send_q.push_back(k[7:0]);
    bus(1, ADR_IRQ_MASK, 32'h1);
    tog_s = 0;
    tog_l = 0;
    press(1);
    wait_irq();
    chk(ctl.got_q.pop_front(), CMD_SAVE);
    chk(exp_q.size(), 0);
    chk(tog_s > 2, 1'b1);
    chk(tog_l, 0);
    bus(0, ADR_COUNT, 0);
    chk(q, 32'h1);
    bus(1, ADR_IRQ_STAT, 32'h1);
    // Load one byte; done only after an 11-bit frame
    prog_running <= 1'b0;
    k = xs();
    card_q.push_back(k[7:0]);
    bus(1, ADR_IRQ_MASK, 32'h2);
    tog_s = 0;
    tog_l = 0;
    press(0);
    wait_irq();
    chk(ctl.got_q.pop_front(), CMD_LOAD);
    chk(ctl.got_q.pop_front(), k[7:0]);
    chk(($time - ctl.t_start) >= 11 * BIT * 10, 1'b1);
    chk(tog_l > 2, 1'b1);
    chk(tog_s, 0);
    bus(0, ADR_COUNT, 0);
    chk(q, 32'h1);
    results();
  end
endmodule
